//--- freq_profile_regs.sv
// Contract
// R1 - Profile A low limit is 16 bits; its own byte register gives bits 15:8.
// R2 - Profile A high limit is 16 bits from two bytes: 7:0 then 15:8.
// R3 - Window cycle field holds cycles minus one; monitor uses value plus one.
// R4 - Prescale bit set divides profile A reference by four before measuring.
// R5 - Software should enable prescale above 19.44 MHz; advisory only.
// R6 - Profile B frequency is 14 bits of 8 kHz: low byte, then bits 5:0.
// R7 - Profile A frequency is 14 bits of 8 kHz: low byte, then bits 5:0.
// R8 - Per-reference 2-bit mode: 0 auto, 1 profile A, 2 profile B, 3 reserved.
// R9 - Reserved bits of prescale and multiplier high bytes reset and read zero.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module freq_profile_regs
  import freq_profile_pkg::*;
(
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  // Wishbone classic slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [freq_profile_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [freq_profile_pkg::SEL_W-1:0]    wb_sel_i,
  input  wire logic [freq_profile_pkg::DAT_W-1:0]    wb_dat_i,
  output var  logic [freq_profile_pkg::DAT_W-1:0]    wb_dat_o,
  output var  logic                                  wb_ack_o,
  // Profile values to the monitor
  output var  logic [freq_profile_pkg::LIMIT_W-1:0]  prof_a_low_limit,
  output var  logic [freq_profile_pkg::LIMIT_W-1:0]  prof_a_high_limit,
  output var  logic [freq_profile_pkg::WIN_W-1:0]    prof_a_window_len,
  output var  logic                                  prof_a_quarter_prescale,
  output var  logic [freq_profile_pkg::MULT_W-1:0]   prof_a_multiplier,
  output var  logic [freq_profile_pkg::MULT_W-1:0]   prof_b_multiplier,
  // Per-reference profile selection and measurement edges
  input  wire logic [freq_profile_pkg::NUM_REFS-1:0] ref_edge,
  output var  logic [freq_profile_pkg::NUM_REFS-1:0] ref_use_a,
  output var  logic [freq_profile_pkg::NUM_REFS-1:0] ref_use_b,
  output var  logic [freq_profile_pkg::NUM_REFS-1:0] mon_edge
);
  import freq_profile_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [2*BYTE_W-1:0]  mode_r;
  logic [BYTE_W-1:0]    a_mult_lo_r;
  logic [MULT_HI_W-1:0] a_mult_hi_r;
  logic [BYTE_W-1:0]    a_low_lo_r;
  logic [BYTE_W-1:0]    a_low_hi_r;
  logic [BYTE_W-1:0]    a_high_lo_r;
  logic [BYTE_W-1:0]    a_high_hi_r;
  logic [BYTE_W-1:0]    a_cycle_r;
  logic                 a_div_r;
  logic [BYTE_W-1:0]    b_mult_lo_r;
  logic [MULT_HI_W-1:0] b_mult_hi_r;
  logic [WIN_W-1:0]     win_len_r;
  logic                 ack_r;
  logic [DAT_W-1:0]     rdata_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack comes one edge after the request and drops the edge after, so a
  // held request is answered only on every second edge.
  wire       req     = wb_cyc_i && wb_stb_i;
  wire       ack_nxt = req && !ack_r;
  wire       wr_en   = ack_nxt && wb_we_i && wb_sel_i[0];
  wire [7:0] idx     = wb_adr_i[9:2];
  wire [7:0] wbyte   = wb_dat_i[7:0];

  wire we_mode_lo = wr_en && (idx == IDX_REF_MODE_LO);
  wire we_mode_hi = wr_en && (idx == IDX_REF_MODE_HI);
  wire we_amlo    = wr_en && (idx == IDX_A_MULT_LO);
  wire we_amhi    = wr_en && (idx == IDX_A_MULT_HI);
  wire we_allo    = wr_en && (idx == IDX_A_LOW_LIM_LO);
  wire we_alhi    = wr_en && (idx == IDX_A_LOW_LIM_HI);
  wire we_ahlo    = wr_en && (idx == IDX_A_HIGH_LIM_LO);
  wire we_ahhi    = wr_en && (idx == IDX_A_HIGH_LIM_HI);
  wire we_acyc    = wr_en && (idx == IDX_A_CYCLE_COUNT);
  wire we_adiv    = wr_en && (idx == IDX_A_PRESCALE);
  wire we_bmlo    = wr_en && (idx == IDX_B_MULT_LO);
  wire we_bmhi    = wr_en && (idx == IDX_B_MULT_HI);

  // Unmapped indices read zero and ignore writes
  wire [7:0] rbyte =
    (idx == IDX_REF_MODE_LO)   ? mode_r[7:0]                    :
    (idx == IDX_REF_MODE_HI)   ? mode_r[15:8]                   :
    (idx == IDX_A_MULT_LO)     ? a_mult_lo_r                    :
    (idx == IDX_A_MULT_HI)     ? {2'h0, a_mult_hi_r}            : // R9
    (idx == IDX_A_LOW_LIM_LO)  ? a_low_lo_r                     :
    (idx == IDX_A_LOW_LIM_HI)  ? a_low_hi_r                     :
    (idx == IDX_A_HIGH_LIM_LO) ? a_high_lo_r                    :
    (idx == IDX_A_HIGH_LIM_HI) ? a_high_hi_r                    :
    (idx == IDX_A_CYCLE_COUNT) ? a_cycle_r                      :
    (idx == IDX_A_PRESCALE)    ? {7'h00, a_div_r}               : // R9
    (idx == IDX_B_MULT_LO)     ? b_mult_lo_r                    :
    (idx == IDX_B_MULT_HI)     ? {2'h0, b_mult_hi_r}            : // R9
                                 RST_BYTE;

  wire [DAT_W-1:0] rdata_nxt = ack_nxt ? {24'h000000, rbyte} : 32'h00000000;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r      <= 16'h0000;
      a_mult_lo_r <= RST_BYTE;
      a_mult_hi_r <= RST_MULT_HI; // R9
      a_low_lo_r  <= RST_BYTE;
      a_low_hi_r  <= RST_BYTE;
      a_high_lo_r <= RST_BYTE;
      a_high_hi_r <= RST_BYTE;
      a_cycle_r   <= RST_BYTE;
      a_div_r     <= 1'b0;        // R9
      b_mult_lo_r <= RST_BYTE;
      b_mult_hi_r <= RST_MULT_HI; // R9
    end else begin
      if (we_mode_lo) mode_r[7:0]  <= wbyte; // R8
      if (we_mode_hi) mode_r[15:8] <= wbyte; // R8
      if (we_amlo)    a_mult_lo_r  <= wbyte; // R7
      if (we_amhi)    a_mult_hi_r  <= wbyte[MULT_HI_W-1:0]; // R7
      if (we_allo)    a_low_lo_r   <= wbyte;
      if (we_alhi)    a_low_hi_r   <= wbyte; // R1
      if (we_ahlo)    a_high_lo_r  <= wbyte; // R2
      if (we_ahhi)    a_high_hi_r  <= wbyte; // R2
      if (we_acyc)    a_cycle_r    <= wbyte;
      if (we_adiv)    a_div_r      <= wbyte[PRESCALE_BIT]; // R4
      if (we_bmlo)    b_mult_lo_r  <= wbyte; // R6
      if (we_bmhi)    b_mult_hi_r  <= wbyte[MULT_HI_W-1:0]; // R6
    end
  end

  // Stored value is cycles minus one; a zero still means one cycle
  always_ff @(posedge clk) begin
    if (!resetn) win_len_r <= 9'h001;
    else         win_len_r <= {1'b0, a_cycle_r} + 9'h001; // R3
  end

  assign wb_ack_o                = ack_r;
  assign wb_dat_o                = rdata_r;
  assign prof_a_low_limit        = {a_low_hi_r, a_low_lo_r};   // R1
  assign prof_a_high_limit       = {a_high_hi_r, a_high_lo_r}; // R2
  assign prof_a_window_len       = win_len_r;
  assign prof_a_quarter_prescale = a_div_r;
  assign prof_a_multiplier       = {a_mult_hi_r, a_mult_lo_r}; // R7
  assign prof_b_multiplier       = {b_mult_hi_r, b_mult_lo_r}; // R6

  // ----------------------------------------------------------------
  // Per-reference selection and quarter prescaler
  // ----------------------------------------------------------------
  // The prescaler counter runs only for profile A references; a mode change
  // restarts it so the first window after a change is not short.
  logic [1:0] qcnt_r [NUM_REFS];

  for (genvar g = 0; g < NUM_REFS; g++) begin : g_ref
    wire [1:0] mode_g = mode_r[2*g+1:2*g];
    wire       sel_a  = (mode_g == MODE_CUSTOM_A);
    wire       sel_b  = (mode_g == MODE_CUSTOM_B);
    wire       quart  = sel_a && a_div_r;
    wire       pass   = quart ? (ref_edge[g] && (qcnt_r[g] == QUARTER_LAST))
                              : ref_edge[g];

    always_ff @(posedge clk) begin
      if (!resetn) begin
        ref_use_a[g] <= 1'b0;
        ref_use_b[g] <= 1'b0;
        mon_edge[g]  <= 1'b0;
        qcnt_r[g]    <= 2'h0;
      end else begin
        ref_use_a[g] <= sel_a; // R8
        ref_use_b[g] <= sel_b; // R8
        mon_edge[g]  <= pass;  // R4
        if (!quart)           qcnt_r[g] <= 2'h0;
        else if (ref_edge[g]) qcnt_r[g] <= qcnt_r[g] + 2'h1; // R4
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOW_LIMIT_HI: assert property (@(posedge clk) disable iff (!resetn) // R1
    we_alhi |=> prof_a_low_limit[15:8] == $past(wb_dat_i[7:0]))
    else $error("low limit upper byte not taken");
  AST_HIGH_LIMIT_LO: assert property (@(posedge clk) disable iff (!resetn) // R2
    we_ahlo |=> (prof_a_high_limit[7:0] == $past(wb_dat_i[7:0]))
                && $stable(prof_a_high_limit[15:8]))
    else $error("high limit lower byte not taken");
  AST_WINDOW_LEN: assert property (@(posedge clk) disable iff (!resetn) // R3
    we_acyc |=> ##1 prof_a_window_len == {1'b0, $past(wb_dat_i[7:0], 2)} + 9'h001)
    else $error("window length not cycles plus one");
  AST_QUARTER_PASS: assert property (@(posedge clk) disable iff (!resetn) // R4
    (ref_edge[0] && !g_ref[0].quart) |=> mon_edge[0])
    else $error("undivided edge lost");
  AST_QUARTER_DIV: assert property (@(posedge clk) disable iff (!resetn) // R4
    (g_ref[0].quart && ref_edge[0] && qcnt_r[0] != QUARTER_LAST) |=> !mon_edge[0])
    else $error("prescaled edge passed early");
  AST_B_MULT_HI: assert property (@(posedge clk) disable iff (!resetn) // R6
    we_bmhi |=> prof_b_multiplier[13:8] == $past(wb_dat_i[5:0]))
    else $error("profile B multiplier high bits wrong");
  AST_A_MULT_LO: assert property (@(posedge clk) disable iff (!resetn) // R7
    we_amlo |=> prof_a_multiplier[7:0] == $past(wb_dat_i[7:0]))
    else $error("profile A multiplier low byte wrong");
  AST_MODE_SELECT: assert property (@(posedge clk) disable iff (!resetn) // R8
    we_mode_hi && (wb_dat_i[7:6] == 2'h3) |=> ##1 !ref_use_a[7] && !ref_use_b[7])
    else $error("reserved mode selected a profile");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!resetn) // R9
    (ack_nxt && !wb_we_i && (idx == IDX_A_PRESCALE || idx == IDX_B_MULT_HI))
      |=> wb_ack_o && (wb_dat_o[31:6] == 26'h0) && (idx != IDX_A_PRESCALE
          || wb_dat_o[5:1] == 5'h00))
    else $error("reserved bits read nonzero");

  COV_WRITE:   cover property (@(posedge clk) disable iff (!resetn) wr_en ##1 wb_ack_o);
  COV_READ:    cover property (@(posedge clk) disable iff (!resetn)
    ack_nxt && !wb_we_i ##1 wb_ack_o);
  COV_QUARTER: cover property (@(posedge clk) disable iff (!resetn)
    g_ref[0].quart && mon_edge[0]);
  COV_USE_B:   cover property (@(posedge clk) disable iff (!resetn) ref_use_b[0]);

endmodule
`default_nettype wire

//--- freq_profile_pkg.sv
`default_nettype none
package freq_profile_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADR_W  = 10;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = 4;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_REF_MODE_LO      = 8'h65;
  localparam logic [7:0] IDX_REF_MODE_HI      = 8'h66;
  localparam logic [7:0] IDX_A_MULT_LO        = 8'h67;
  localparam logic [7:0] IDX_A_MULT_HI        = 8'h68;
  localparam logic [7:0] IDX_A_LOW_LIM_LO     = 8'h6B;
  localparam logic [7:0] IDX_A_LOW_LIM_HI     = 8'h6C;
  localparam logic [7:0] IDX_A_HIGH_LIM_LO    = 8'h6D;
  localparam logic [7:0] IDX_A_HIGH_LIM_HI    = 8'h6E;
  localparam logic [7:0] IDX_A_CYCLE_COUNT    = 8'h6F;
  localparam logic [7:0] IDX_A_PRESCALE       = 8'h70;
  localparam logic [7:0] IDX_B_MULT_LO        = 8'h71;
  localparam logic [7:0] IDX_B_MULT_HI        = 8'h72;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [5:0] RST_MULT_HI  = 6'h00;
  localparam int         MULT_HI_W    = 6;
  localparam int         MULT_W       = 14;
  localparam int         LIMIT_W      = 16;
  localparam int         WIN_W        = 9;
  localparam int         PRESCALE_BIT = 0;
  localparam int         NUM_REFS     = 8;
  localparam int         MODE_W       = 2;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef enum logic [1:0] {
    MODE_AUTO     = 2'h0,
    MODE_CUSTOM_A = 2'h1,
    MODE_CUSTOM_B = 2'h2,
    MODE_RESERVED = 2'h3
  } freq_mode_t;

endpackage
`default_nettype wire

//--- tb_freq_profile_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_freq_profile_regs;
  import freq_profile_pkg::*;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic                clk;
  logic                resetn;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [ADR_W-1:0]    adr;
  logic [SEL_W-1:0]    sel;
  logic [DAT_W-1:0]    dat_w;
  logic [DAT_W-1:0]    dat_r;
  logic                ack;
  logic [LIMIT_W-1:0]  lo_lim;
  logic [LIMIT_W-1:0]  hi_lim;
  logic [WIN_W-1:0]    win;
  logic                presc;
  logic [MULT_W-1:0]   mult_a;
  logic [MULT_W-1:0]   mult_b;
  logic [NUM_REFS-1:0] ref_edge;
  logic [NUM_REFS-1:0] use_a;
  logic [NUM_REFS-1:0] use_b;
  logic [NUM_REFS-1:0] mon_edge;
  logic [7:0]          shadow [256];
  int                  n_errors;
  int                  checks_done;
  int                  cycles;
  int                  mon_cnt;
  localparam logic [7:0] IDX_LIST [12] = '{IDX_REF_MODE_LO, IDX_REF_MODE_HI, IDX_A_MULT_LO,
    IDX_A_MULT_HI, IDX_A_LOW_LIM_LO, IDX_A_LOW_LIM_HI, IDX_A_HIGH_LIM_LO, IDX_A_HIGH_LIM_HI,
    IDX_A_CYCLE_COUNT, IDX_A_PRESCALE, IDX_B_MULT_LO, IDX_B_MULT_HI};
  // Corner bytes: all-ones gives a 256-cycle window and reserved modes
  localparam logic [7:0] CORNER [4] = '{8'hFF, 8'h00, 8'h55, 8'hAA};

  freq_profile_regs dut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .prof_a_low_limit(lo_lim), .prof_a_high_limit(hi_lim), .prof_a_window_len(win),
    .prof_a_quarter_prescale(presc), .prof_a_multiplier(mult_a),
    .prof_b_multiplier(mult_b), .ref_edge(ref_edge), .ref_use_a(use_a),
    .ref_use_b(use_b), .mon_edge(mon_edge));

  // ----------------------------------------------------------------
  // Expectations, compare, bus and closing tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] rmask(input logic [7:0] idx);
    if (idx == IDX_A_MULT_HI || idx == IDX_B_MULT_HI) return 8'h3F;
    if (idx == IDX_A_PRESCALE) return 8'h01;
    return 8'hFF;
  endfunction
  function automatic logic [7:0] use_of(input logic [15:0] modes, input logic [1:0] m);
    logic [7:0] r;
    for (int n = 0; n < 8; n++) r[n] = (modes[2*n +: 2] == m);
    return r;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Holds the request until ack is sampled; data is taken at that edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic s0, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'h7, s0};
    dat_w <= {24'hC3C3C3, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic check_outputs();
    chk(32'(lo_lim), {16'h0, shadow[IDX_A_LOW_LIM_HI], shadow[IDX_A_LOW_LIM_LO]}, "low");
    chk(32'(hi_lim), {16'h0, shadow[IDX_A_HIGH_LIM_HI], shadow[IDX_A_HIGH_LIM_LO]}, "hi");
    chk(32'(win), 32'(shadow[IDX_A_CYCLE_COUNT]) + 32'd1, "window");
    chk(32'(presc), 32'(shadow[IDX_A_PRESCALE][PRESCALE_BIT]), "prescale");
    chk(32'(mult_a), {18'h0, shadow[IDX_A_MULT_HI][5:0], shadow[IDX_A_MULT_LO]}, "mult a");
    chk(32'(mult_b), {18'h0, shadow[IDX_B_MULT_HI][5:0], shadow[IDX_B_MULT_LO]}, "mult b");
    chk(32'(use_a), 32'(use_of({shadow[IDX_REF_MODE_HI], shadow[IDX_REF_MODE_LO]}, 2'd1)), "use a");
    chk(32'(use_b), 32'(use_of({shadow[IDX_REF_MODE_HI], shadow[IDX_REF_MODE_LO]}, 2'd2)), "use b");
  endtask
  // Other references see random edges so their logic is exercised too
  task automatic pulse_run(input int n, input int exp_cnt, input string what);
    mon_cnt = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      ref_edge <= {7'($urandom), 1'b1};
    end
    @(posedge clk);
    ref_edge <= 8'h00;
    repeat (3) @(posedge clk);
    chk(32'(mon_cnt), 32'(exp_cnt), what);
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and edge counter
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (mon_edge[0] === 1'b1) mon_cnt <= mon_cnt + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [7:0]  d;
    {resetn, cyc, stb, we, adr, sel, dat_w, ref_edge} = '0;
    {n_errors, checks_done, cycles, mon_cnt} = '0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    q = $urandom(32'h8F83);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(win), 32'd1, "window after reset");
    foreach (IDX_LIST[i]) begin
      wb(1'b0, IDX_LIST[i], 8'h00, 1'b1, q);
      chk(q, 32'h0, "reset value");
    end
    for (int r = 0; r < 8; r++) begin
      foreach (IDX_LIST[i]) begin
        // Reserved bits go out as zero, as software must leave them at default
        d = ((r < 4) ? CORNER[r] : 8'($urandom)) & rmask(IDX_LIST[i]);
        shadow[IDX_LIST[i]] = d;
        wb(1'b1, IDX_LIST[i], d, 1'b1, q);
      end
      foreach (IDX_LIST[i]) begin
        wb(1'b0, IDX_LIST[i], 8'h00, 1'b1, q);
        chk(q, {24'h0, shadow[IDX_LIST[i]]}, "readback");
      end
      check_outputs();
    end
    // Byte lane off and an unmapped index must both leave the bank untouched
    wb(1'b1, IDX_A_LOW_LIM_HI, ~shadow[IDX_A_LOW_LIM_HI], 1'b0, q);
    wb(1'b1, 8'h69, 8'h5A, 1'b1, q);
    wb(1'b0, 8'h69, 8'h00, 1'b1, q);
    chk(q, 32'h0, "unmapped read");
    check_outputs();
    shadow[IDX_A_PRESCALE] = 8'h00;
    wb(1'b1, IDX_REF_MODE_LO, 8'h01, 1'b1, q);
    wb(1'b1, IDX_A_PRESCALE, 8'h00, 1'b1, q);
    pulse_run(5, 5, "edges unscaled");
    // Edges every cycle stand for the fastest reference, so prescale goes on
    wb(1'b1, IDX_A_PRESCALE, 8'h01, 1'b1, q);
    pulse_run(8, 2, "edges quartered");
    pulse_run(6, 1, "edges quartered tail");
    wb(1'b1, IDX_REF_MODE_LO, 8'h02, 1'b1, q);
    pulse_run(3, 3, "edges profile b");
    wb(1'b1, IDX_REF_MODE_LO, 8'h00, 1'b1, q);
    pulse_run(3, 3, "edges auto");
    close_out();
  end
endmodule
`default_nettype wire
